// [verilog/mlsf_pkg.sv]
package mlsf_pkg;
   localparam int unsigned INSTR_BITS = 8;
   localparam int unsigned ADDR_BITS = 24;
   localparam int unsigned MODE_BITS = 8;
   localparam int unsigned TRAIN_CYCLES = 4;
   localparam logic [7:0] TRAIN_PATTERN = 8'h34;
   // instruction codes
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FAST_READ = 8'h0b;
   localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
   localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
   localparam logic [7:0] OP_DUAL_IO = 8'hbb;
   localparam logic [7:0] OP_QUAD_IO = 8'heb;
   localparam logic [7:0] OP_QUAD_PAGE_WRITE = 8'h32;
   localparam logic [7:0] OP_DDR_FAST = 8'h0d;
   localparam logic [7:0] OP_DDR_DUAL = 8'hbd;
   localparam logic [7:0] OP_DDR_QUAD = 8'hed;
   // latency cycles per latency code
   localparam logic [3:0] LAT_CODE0 = 4'h8;
   localparam logic [3:0] LAT_CODE1 = 4'h0;
   localparam logic [3:0] LAT_CODE2 = 4'h2;
   localparam logic [3:0] LAT_CODE3 = 4'h4;
   localparam logic [3:0] DDR_LAT_CODE0 = 4'h6;
   localparam logic [3:0] DDR_LAT_CODE1 = 4'h5;
   localparam logic [3:0] DDR_LAT_CODE2 = 4'h6;
   localparam logic [3:0] DDR_LAT_CODE3 = 4'h7;

   typedef enum logic [11:0] {
      ST_STANDBY = 12'h001,
      ST_INSTR = 12'h002,
      ST_SIN = 12'h004,
      ST_DIN = 12'h008,
      ST_QIN = 12'h010,
      ST_DDR_IN = 12'h020,
      ST_LAT = 12'h040,
      ST_SOUT = 12'h080,
      ST_DOUT = 12'h100,
      ST_QOUT = 12'h200,
      ST_QWDATA = 12'h400,
      ST_IGNORE = 12'h800
   } mlsf_state_e;

   // lane width per phase
   typedef enum logic [1:0] {
      W_SINGLE = 2'h0,
      W_DUAL = 2'h1,
      W_QUAD = 2'h2
   } mlsf_width_e;

   // four data lanes, three signals each
   typedef struct packed {
      logic [3:0] in;
      logic [3:0] out;
      logic [3:0] oe_b;
   } mlsf_lanes_s;

   // captured address and mode for the read engine
   typedef struct packed {
      logic [ADDR_BITS-1:0] addr;
      logic [MODE_BITS-1:0] mode;
      logic is_write;
   } mlsf_req_s;
endpackage

// [verilog/mlsf_fifo.sv]
`timescale 1ns/1ns
module mlsf_fifo import mlsf_pkg::*; #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 32
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic flush,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int unsigned AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) $error("mlsf_fifo: depth must be power of two");
   end
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
   logic push, pop;
   // honest full and empty from wrap bit
   assign in_ready = (wr_reg[AW-1:0] != rd_reg[AW-1:0]) || (wr_reg[AW] == rd_reg[AW]);
   assign out_valid = wr_reg != rd_reg;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_reg[rd_reg[AW-1:0]];
   // pointer update
   always_comb begin
      wr_next = wr_reg;
      rd_next = rd_reg;
      if (flush) begin
         wr_next = '0;
         rd_next = '0;
      end else begin
         if (push) wr_next = wr_reg + 1'b1;
         if (pop) rd_next = rd_reg + 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
      end
   end
   // storage written by index
   always_ff @(posedge clk) begin
      if (push) mem_reg[wr_reg[AW-1:0]] <= in_data;
   end
endmodule // mlsf_fifo

// [verilog/mlsf_phase_seq.sv]
`timescale 1ns/1ns
module mlsf_phase_seq import mlsf_pkg::*; #(
   parameter int unsigned FIFO_DEPTH = 32
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic sck,
   input wire logic cs_b,
   input wire logic [3:0] lane_in,
   output logic [3:0] lane_out,
   output logic [3:0] lane_oe_b,
   input wire logic [1:0] latency_code_field,
   input wire logic quad_enable_bit,
   input wire logic train_enable,
   output logic [7:0] rd_data_req_addr_byte,
   input wire logic [7:0] rd_byte,
   input wire logic rd_valid,
   output logic rd_ready,
   output logic [7:0] wr_byte,
   output logic wr_valid,
   input wire logic wr_ready,
   output mlsf_req_s req,
   output logic req_valid,
   output logic cmd_end,
   output logic wr_overflow
);
   initial begin
      if (FIFO_DEPTH < 2) $error("mlsf_phase_seq: fifo too shallow");
   end
   mlsf_state_e st_reg, st_next;
   mlsf_width_e wid_reg, wid_next;
   logic sck_reg, cs_reg;
   logic rise, fall, cs_fall, cs_rise;
   logic [7:0] op_reg, op_next;
   logic [5:0] cnt_reg, cnt_next;
   logic [ADDR_BITS+MODE_BITS-1:0] sh_reg, sh_next;
   logic [3:0] lat_reg, lat_next;
   logic ddr_reg, ddr_next, lat_ddr_reg, lat_ddr_next;
   logic [7:0] obyte_reg, obyte_next;
   logic [3:0] obit_reg, obit_next;
   logic [3:0] out_reg, out_next;
   logic [3:0] oe_b_reg, oe_b_next;
   logic [7:0] ib_reg, ib_next;
   logic [3:0] ibit_reg, ibit_next;
   logic [5:0] alen;
   logic [3:0] lat_cycles;
   logic in_push, out_pop, req_v_next, req_v_reg, end_next, end_reg, ovf_next, ovf_reg;
   logic [7:0] fifo_out;
   logic fifo_ovalid, fifo_iready;
   logic [2:0] step;
   mlsf_req_s req_reg, req_next;

   // edge detect of host pins; pins are synchronous to clk
   assign rise = sck && !sck_reg;
   assign fall = !sck && sck_reg;
   assign cs_fall = !cs_b && cs_reg;
   assign cs_rise = cs_b && !cs_reg;

   // bits per edge for current width
   always_comb begin
      case (wid_reg)
         W_DUAL: step = 3'h2;
         W_QUAD: step = 3'h4;
         default: step = 3'h1;
      endcase
   end

   // latency count by code, separate table for DDR
   always_comb begin
      case (latency_code_field)
         2'h0: lat_cycles = ddr_reg ? DDR_LAT_CODE0 : LAT_CODE0;
         2'h1: lat_cycles = ddr_reg ? DDR_LAT_CODE1 : LAT_CODE1;
         2'h2: lat_cycles = ddr_reg ? DDR_LAT_CODE2 : LAT_CODE2;
         default: lat_cycles = ddr_reg ? DDR_LAT_CODE3 : LAT_CODE3;
      endcase
   end

   // address plus mode length in bits for the instruction
   always_comb begin
      case (op_reg)
         OP_DUAL_IO, OP_QUAD_IO, OP_DDR_FAST, OP_DDR_DUAL, OP_DDR_QUAD: alen = 6'(ADDR_BITS + MODE_BITS);
         default: alen = 6'(ADDR_BITS);
      endcase
   end

   // read bytes stream through fifo toward the pins
   mlsf_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst_b(rst_b),
      .flush(cs_b),
      .in_data(rd_byte),
      .in_valid(rd_valid),
      .in_ready(fifo_iready),
      .out_data(fifo_out),
      .out_valid(fifo_ovalid),
      .out_ready(out_pop)
   );
   assign rd_ready = fifo_iready && !cs_b;
   assign rd_data_req_addr_byte = req_reg.addr[7:0];

   // phase sequencer
   always_comb begin
      st_next = st_reg;
      wid_next = wid_reg;
      op_next = op_reg;
      cnt_next = cnt_reg;
      sh_next = sh_reg;
      lat_next = lat_reg;
      ddr_next = ddr_reg;
      lat_ddr_next = lat_ddr_reg;
      obyte_next = obyte_reg;
      obit_next = obit_reg;
      out_next = out_reg;
      oe_b_next = 4'hf;
      ib_next = ib_reg;
      ibit_next = ibit_reg;
      req_next = req_reg;
      req_v_next = 1'b0;
      end_next = 1'b0;
      in_push = 1'b0;
      out_pop = 1'b0;
      ovf_next = ovf_reg;
      if (cs_b) begin
         // select high ends any phase
         if (st_reg != ST_STANDBY) end_next = 1'b1;
         st_next = ST_STANDBY;
         oe_b_next = 4'hf;
      end else begin
         case (st_reg)
            ST_STANDBY: begin
               if (cs_fall || !cs_b) begin
                  st_next = ST_INSTR;
                  cnt_next = '0;
                  ovf_next = 1'b0;
                  ddr_next = 1'b0;
               end
            end
            ST_INSTR: begin
               if (rise) begin
                  op_next = {op_reg[6:0], lane_in[0]};
                  cnt_next = cnt_reg + 6'h1;
                  if (cnt_reg == 6'(INSTR_BITS - 1)) begin
                     cnt_next = '0;
                     sh_next = '0;
                     // instruction picks format of what follows
                     case ({op_reg[6:0], lane_in[0]})
                        OP_READ, OP_FAST_READ, OP_DUAL_OUT: begin
                           st_next = ST_SIN;
                           wid_next = W_SINGLE;
                        end
                        OP_QUAD_OUT, OP_QUAD_PAGE_WRITE: begin
                           st_next = quad_enable_bit ? ST_SIN : ST_IGNORE;
                           wid_next = W_SINGLE;
                        end
                        OP_DUAL_IO: begin
                           st_next = ST_DIN;
                           wid_next = W_DUAL;
                        end
                        OP_QUAD_IO: begin
                           st_next = quad_enable_bit ? ST_QIN : ST_IGNORE;
                           wid_next = W_QUAD;
                        end
                        OP_DDR_FAST: begin
                           st_next = ST_DDR_IN;
                           wid_next = W_SINGLE;
                           ddr_next = 1'b1;
                        end
                        OP_DDR_DUAL: begin
                           st_next = ST_DDR_IN;
                           wid_next = W_DUAL;
                           ddr_next = 1'b1;
                        end
                        OP_DDR_QUAD: begin
                           st_next = quad_enable_bit ? ST_DDR_IN : ST_IGNORE;
                           wid_next = W_QUAD;
                           ddr_next = 1'b1;
                        end
                        default: st_next = ST_IGNORE;
                     endcase
                  end
               end
            end
            ST_SIN, ST_DIN, ST_QIN, ST_DDR_IN: begin
               // serial input sampled on rise, on fall too in DDR; lanes 0 only in single
               // first ddr bit rides a rising edge; the fall after the instruction carries none
               if (rise || (ddr_reg && fall && cnt_reg != '0)) begin
                  case (wid_reg)
                     W_DUAL: sh_next = {sh_reg[ADDR_BITS+MODE_BITS-3:0], lane_in[1:0]};
                     W_QUAD: sh_next = {sh_reg[ADDR_BITS+MODE_BITS-5:0], lane_in};
                     default: sh_next = {sh_reg[ADDR_BITS+MODE_BITS-2:0], lane_in[0]};
                  endcase
                  cnt_next = cnt_reg + 6'(step);
                  if (cnt_reg + 6'(step) >= alen) begin
                     cnt_next = '0;
                     req_v_next = 1'b1;
                     req_next.is_write = (op_reg == OP_QUAD_PAGE_WRITE);
                     if (alen == 6'(ADDR_BITS)) begin
                        req_next.addr = sh_next[ADDR_BITS-1:0];
                        req_next.mode = '0;
                     end else begin
                        req_next.addr = sh_next[ADDR_BITS+MODE_BITS-1:MODE_BITS];
                        req_next.mode = sh_next[MODE_BITS-1:0];
                     end
                     lat_next = lat_cycles;
                     lat_ddr_next = ddr_reg;
                     // output width follows the instruction
                     case (op_reg)
                        OP_DUAL_OUT, OP_DUAL_IO, OP_DDR_DUAL: wid_next = W_DUAL;
                        OP_QUAD_OUT, OP_QUAD_IO, OP_DDR_QUAD, OP_QUAD_PAGE_WRITE: wid_next = W_QUAD;
                        default: wid_next = W_SINGLE;
                     endcase
                     if (op_reg == OP_QUAD_PAGE_WRITE) begin
                        st_next = ST_QWDATA;
                        ibit_next = '0;
                     end else if (ddr_reg) begin
                        st_next = ST_LAT;
                     end else if (op_reg == OP_READ || lat_cycles == '0) begin
                        st_next = ST_LAT;
                        lat_next = '0;
                     end else begin
                        st_next = ST_LAT;
                     end
                     obit_next = '0;
                  end
               end
            end
            ST_LAT: begin
               // lanes ignored and undriven while latency counts down, except DDR training drives the pattern in the last four counts
               oe_b_next = 4'hf;
               if (lat_ddr_reg && train_enable && lat_reg <= 4'(TRAIN_CYCLES) && lat_reg != '0) begin
                  oe_b_next = 4'h0;
                  out_next = {4{TRAIN_PATTERN[lat_reg[2:0] - 3'h1]}};
               end
               if (lat_reg == '0) begin
                  case (wid_reg)
                     W_DUAL: st_next = ST_DOUT;
                     W_QUAD: st_next = ST_QOUT;
                     default: st_next = ST_SOUT;
                  endcase
                  oe_b_next = 4'hf;
               end else if (fall) begin
                  lat_next = lat_reg - 4'h1;
               end
            end
            ST_SOUT, ST_DOUT, ST_QOUT: begin
               // launch on falling edge; write-guard and lane 0 ignored in single
               case (st_reg)
                  ST_QOUT: oe_b_next = 4'h0;
                  ST_DOUT: oe_b_next = 4'hc;
                  default: oe_b_next = 4'hd;
               endcase
               // drivers turn on at the first fall only, once the host has let go
               if (!fall && oe_b_reg == 4'hf) oe_b_next = 4'hf;
               if (fall && fifo_ovalid) begin
                  case (st_reg)
                     ST_QOUT: out_next = obit_reg[0] ? fifo_out[3:0] : fifo_out[7:4];
                     ST_DOUT: out_next = {2'h0, fifo_out[3'h7 - {obit_reg[1:0], 1'b0} -: 2]};
                     default: out_next = {2'h0, fifo_out[3'h7 - obit_reg[2:0]], 1'b0};
                  endcase
                  obit_next = obit_reg + 4'h1;
                  if (obit_next == 4'(8 / step)) begin
                     obit_next = '0;
                     out_pop = 1'b1;
                  end
               end
               // output phase repeats until select rises
               st_next = st_reg;
            end
            ST_QWDATA: begin
               // four data bits per rising edge into bytes
               if (rise) begin
                  ib_next = {ib_reg[3:0], lane_in};
                  ibit_next = ibit_reg + 4'h1;
                  if (ibit_reg[0]) begin
                     in_push = 1'b1;
                     if (!wr_ready) ovf_next = 1'b1;
                  end
               end
            end
            ST_IGNORE: st_next = ST_IGNORE;
            default: st_next = ST_STANDBY;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st_reg <= ST_STANDBY;
         wid_reg <= W_SINGLE;
         sck_reg <= 1'b0;
         cs_reg <= 1'b1;
         op_reg <= '0;
         cnt_reg <= '0;
         sh_reg <= '0;
         lat_reg <= '0;
         ddr_reg <= 1'b0;
         lat_ddr_reg <= 1'b0;
         obyte_reg <= '0;
         obit_reg <= '0;
         out_reg <= '0;
         oe_b_reg <= 4'hf;
         ib_reg <= '0;
         ibit_reg <= '0;
         req_reg <= '0;
         req_v_reg <= 1'b0;
         end_reg <= 1'b0;
         ovf_reg <= 1'b0;
         wr_byte <= '0;
         wr_valid <= 1'b0;
      end else begin
         st_reg <= st_next;
         wid_reg <= wid_next;
         sck_reg <= sck;
         cs_reg <= cs_b;
         op_reg <= op_next;
         cnt_reg <= cnt_next;
         sh_reg <= sh_next;
         lat_reg <= lat_next;
         ddr_reg <= ddr_next;
         lat_ddr_reg <= lat_ddr_next;
         obyte_reg <= obyte_next;
         obit_reg <= obit_next;
         out_reg <= out_next;
         oe_b_reg <= oe_b_next;
         ib_reg <= ib_next;
         ibit_reg <= ibit_next;
         req_reg <= req_next;
         req_v_reg <= req_v_next;
         end_reg <= end_next;
         ovf_reg <= ovf_next;
         wr_byte <= in_push ? ib_next : wr_byte;
         wr_valid <= in_push;
      end
   end

   assign lane_out = out_reg;
   assign lane_oe_b = oe_b_reg;
   assign req = req_reg;
   assign req_valid = req_v_reg;
   assign cmd_end = end_reg;
   assign wr_overflow = ovf_reg;
endmodule // mlsf_phase_seq

// [tb/mlsf_phase_seq_chk.sv]
`timescale 1ns/1ns
module mlsf_phase_seq_chk import mlsf_pkg::*; #(
   parameter int unsigned FIFO_DEPTH = 32
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic sck,
   input wire logic cs_b,
   input wire logic [3:0] lane_out,
   input wire logic [3:0] lane_oe_b,
   input wire logic wr_valid,
   input wire logic req_valid,
   input wire logic cmd_end
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   // deselect hands every lane back next cycle
   a_cs_release: assert property (cs_b |=> lane_oe_b == 4'hf)
      else $error("lanes still driven after deselect");
   // only single, dual or quad drive sets
   a_lane_sets: assert property (lane_oe_b inside {4'hf, 4'hd, 4'hc, 4'h0})
      else $error("illegal lane drive set");
   // all lanes released for the first eight clocks after select falls
   a_instr_quiet: assert property ($fell(cs_b) |-> lane_oe_b == 4'hf [*8])
      else $error("lane driven during instruction");
   // one request per address phase
   a_req_pulse: assert property (req_valid |=> !req_valid [*3])
      else $error("request pulse too long");
   // end pulse only once deselected
   a_end_pulse: assert property (cmd_end |-> cs_b ##1 !cmd_end)
      else $error("bad command end pulse");
   // write bytes need two serial cycles each
   a_wr_space: assert property (wr_valid |=> !wr_valid [*6])
      else $error("write bytes too close");
   // output bits launched while the serial clock is low
   a_out_launch: assert property (!cs_b && !$stable(lane_out) |-> !sck)
      else $error("output changed with clock high");
   // memory takes the lanes only after a falling edge
   a_drive_start: assert property ($fell(lane_oe_b[1]) |-> !sck)
      else $error("lane turned on with clock high");
endmodule // mlsf_phase_seq_chk

bind mlsf_phase_seq mlsf_phase_seq_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.clk(clk), .rst_b(rst_b),
   .sck(sck), .cs_b(cs_b), .lane_out(lane_out), .lane_oe_b(lane_oe_b), .wr_valid(wr_valid),
   .req_valid(req_valid), .cmd_end(cmd_end));

// [tb/mlsf_host.sv]
`timescale 1ns/1ns
module mlsf_host (
   input wire logic clk,
   input wire logic [3:0] lane_out,
   input wire logic [3:0] lane_oe_b,
   output logic sck,
   output logic cs_b,
   output logic [3:0] lane_in
);
   logic [3:0] hv, hen, junk;
   logic [63:0] rx;
   logic lat_drive;

   // wire level: memory first, then host, else a wandering float
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         lane_in[i] = !lane_oe_b[i] ? lane_out[i] : (hen[i] ? hv[i] : junk[i]);
      end
   end
   // released lanes flip every cycle
   always @(posedge clk) junk <= ~junk;

   initial begin
      sck = 0;
      cs_b = 1;
      hv = 0;
      hen = 0;
      junk = 4'h5;
      rx = 0;
      lat_drive = 0;
   end

   // set lanes, then move the serial clock
   task automatic half(input logic lv, input logic [3:0] d, input logic [3:0] en);
      hv = d;
      hen = en;
      repeat (2) @(negedge clk);
      sck = lv;
      repeat (2) @(negedge clk);
   endtask

   // send n bits, w lanes wide, msb first
   task automatic send(input logic [31:0] v, input int n, input int w, input bit ddr);
      logic [3:0] d, m;
      m = 4'((1 << w) - 1);
      if (ddr) half(0, 4'(v >> (n - w)) & m, m);
      for (int k = 0; k < n / w; k++) begin
         d = 4'(v >> (n - w - k * w)) & m;
         if (!ddr) half(0, d, m);
         half(ddr ? !k[0] : 1'b1, d, m);
      end
   endtask

   task automatic start(input logic [7:0] op);
      cs_b = 0;
      send({24'h0, op}, 8, 1, 0);
   endtask

   // latency cycles with every lane released
   task automatic idle(input int n);
      for (int k = 0; k < 2 * n; k++) begin
         if (lane_oe_b !== 4'hf) lat_drive = 1;
         half(!sck, 4'h0, 4'h0);
      end
   endtask

   // sample output before each rising edge
   task automatic recv(input int n, input int ow);
      for (int k = 0; k < n; k++) begin
         half(0, 4'h0, 4'h0);
         rx = (rx << ow) | (ow == 1 ? 64'(lane_out[1]) : 64'(lane_out & 4'((1 << ow) - 1)));
         half(1, 4'h0, 4'h0);
      end
   endtask

   task automatic stop();
      cs_b = 1;
      repeat (6) @(negedge clk);
   endtask
endmodule // mlsf_host

// [tb/mlsf_phase_seq_test.sv]
`timescale 1ns/1ns
module mlsf_phase_seq_test import mlsf_pkg::*;;
   logic clk, rst_b, sck, cs_b, quad_en, train_en, rd_valid, rd_ready, wr_valid, wr_ready;
   logic req_valid, cmd_end, wr_overflow, took, saw_full, gw;
   logic [3:0] lane_in, lane_out, lane_oe_b;
   logic [1:0] lat;
   logic [7:0] rd_byte, wr_byte, ab, gm;
   logic [23:0] ga;
   logic [31:0] d;
   mlsf_req_s req;
   int miscompares = 0;
   int tests_run = 0;
   int nreq = 0;
   int nend = 0;
   int n0;
   logic [7:0] q[$];
   logic [7:0] wq[$];
   logic [7:0] ops[9] = '{OP_READ, OP_FAST_READ, OP_DUAL_OUT, OP_QUAD_OUT, OP_DUAL_IO, OP_QUAD_IO,
      OP_DDR_FAST, OP_DDR_DUAL, OP_DDR_QUAD};
   int aw[9] = '{1, 1, 1, 1, 2, 4, 1, 2, 4};
   int owd[9] = '{1, 1, 2, 4, 2, 4, 1, 2, 4};

   mlsf_phase_seq #(.FIFO_DEPTH(32)) uut (.clk(clk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b),
      .lane_in(lane_in), .lane_out(lane_out), .lane_oe_b(lane_oe_b), .latency_code_field(lat),
      .quad_enable_bit(quad_en), .train_enable(train_en), .rd_data_req_addr_byte(ab), .rd_byte(rd_byte),
      .rd_valid(rd_valid), .rd_ready(rd_ready), .wr_byte(wr_byte), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .req(req), .req_valid(req_valid), .cmd_end(cmd_end), .wr_overflow(wr_overflow));
   mlsf_host host (.clk(clk), .lane_out(lane_out), .lane_oe_b(lane_oe_b), .sck(sck), .cs_b(cs_b),
      .lane_in(lane_in));

   initial begin
      clk = 0;
      forever #4 clk = ~clk;
   end

   // watch requests, write bytes and buffer refusals
   always @(posedge clk) begin
      took <= rd_valid && rd_ready;
      if (req_valid) begin
         ga <= req.addr;
         gm <= req.mode;
         gw <= req.is_write;
         nreq <= nreq + 1;
      end
      if (wr_valid) wq.push_back(wr_byte);
      if (cmd_end) nend <= nend + 1;
      if (rd_valid && !rd_ready && !cs_b) saw_full <= 1'b1;
   end

   // offer read bytes with random stalls, held until taken
   always @(negedge clk) begin
      if (took) void'(q.pop_front());
      if (took || !rd_valid || q.size() == 0) begin
         rd_valid <= q.size() != 0 && $urandom_range(3) != 0;
         rd_byte <= q.size() != 0 ? q[0] : 8'h00;
      end
   end

   function automatic int lat_of(input int i, input logic [1:0] c);
      logic [3:0] s[4];
      logic [3:0] t[4];
      s = '{LAT_CODE0, LAT_CODE1, LAT_CODE2, LAT_CODE3};
      t = '{DDR_LAT_CODE0, DDR_LAT_CODE1, DDR_LAT_CODE2, DDR_LAT_CODE3};
      if (i == 0) return 0;
      return i >= 6 ? int'(t[c]) : int'(s[c]);
   endfunction

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // one read of format i under latency code c
   task automatic rd(input int i, input logic [1:0] c);
      logic [31:0] am;
      logic [15:0] e;
      int n;
      bit ddr;
      int m0;
      am = $urandom;
      n = i >= 4 ? 32 : 24;
      ddr = i >= 6;
      n0 = nreq;
      m0 = nend;
      lat = c;
      host.lat_drive = 0;
      host.rx = 0;
      host.start(ops[i]);
      for (int k = 0; k < 40; k++) q.push_back(8'($urandom));
      e = {q[0], q[1]};
      host.send(am, n, aw[i], ddr);
      host.idle(lat_of(i, c));
      host.recv(ddr ? 0 : 16 / owd[i], owd[i]);
      host.stop();
      q = {};
      chk(nreq - n0, 1);
      chk(ga, n > 24 ? am[31:8] : am[23:0]);
      chk(ab, n > 24 ? am[15:8] : am[7:0]);
      if (n > 24) chk(gm, am[7:0]);
      chk(host.lat_drive, ddr && train_en);
      chk(nend - m0, 1);
      if (!ddr) chk(host.rx[15:0], e);
      $display("read format %0d code %0d done", i, c);
   endtask

   initial begin
      rst_b = 0;
      quad_en = 1;
      train_en = 0;
      wr_ready = 1;
      lat = 1;
      rd_valid = 0;
      rd_byte = 0;
      took = 0;
      saw_full = 0;
      void'($urandom(32'h0000_219e));
      repeat (16) @(negedge clk);
      rst_b = 1;
      repeat (2) @(negedge clk);
      // every read format, then longest and zero latency corners
      for (int i = 0; i < 9; i++) rd(i, 2'($urandom));
      rd(1, 2'h0);
      rd(4, 2'h1);
      rd(5, 2'h1);
      // ddr read with the training pattern in the last latency cycles
      train_en = 1;
      rd(7, 2'h0);
      train_en = 0;
      chk(saw_full, 1);
      // quad read refused with quad mode off
      quad_en = 0;
      n0 = nreq;
      host.lat_drive = 0;
      host.start(OP_QUAD_IO);
      host.send($urandom, 32, 4, 0);
      host.idle(4);
      host.stop();
      chk(nreq - n0, 0);
      chk(host.lat_drive, 0);
      $display("refused quad read done");
      quad_en = 1;
      // quad write accepted, then with the sink refusing
      for (int k = 0; k < 2; k++) begin
         wr_ready = !k[0];
         wq = {};
         d = $urandom;
         host.start(OP_QUAD_PAGE_WRITE);
         host.send($urandom, 24, 1, 0);
         host.send(d, 32, 4, 0);
         host.stop();
         if (k == 0) chk({wq[0], wq[1], wq[2], wq[3]}, d);
         chk(gw, 1);
         chk(wr_overflow, k);
         $display("quad write %0d done", k);
      end
      end_of_test();
   end

   // hang guard
   initial begin
      repeat (60000) @(posedge clk);
      miscompares++;
      end_of_test();
   end
endmodule // mlsf_phase_seq_test
